//--- hw/gcm_pkg.sv
// Purpose: shared constants and types for the glitch-free clock mux
// Assumes: APB3 slave, 32-bit data, 8-bit byte address
// Notes:   input clocks are far slower than the system clock
`default_nettype none

package gcm_pkg;

	// system clock rate
	localparam int unsigned CLK_HZ   = 20_000_000;

	// APB register byte addresses
	localparam int          ADDR_W   = 8;
	localparam logic [7:0]  ADDR_CTRL   = 8'h00;
	localparam logic [7:0]  ADDR_STAT   = 8'h04;
	localparam logic [7:0]  ADDR_MAP_LO = 8'h08;
	localparam logic [7:0]  ADDR_MAP_HI = 8'h0c;

	// control reset values (select comes from the boot pick)
	localparam logic        CTRL_EN_RST  = 1'b1;
	localparam logic        CTRL_BYP_RST = 1'b0;

	// status field positions
	localparam int          STAT_SRC  = 0;
	localparam int          STAT_GATE = 1;
	localparam int          STAT_PEND = 2;
	localparam int          STAT_OUT  = 3;
	localparam int          STAT_W    = 4;

	// region map: eight fields, one per byte, two words
	localparam int          REGION_CLKS = 8;
	localparam int          SEL_W       = 5;
	localparam int          FIELD_W     = 8;
	localparam int          FIELDS_WORD = 4;

	// control word, bits [3:0] of the control register
	typedef struct packed {
		logic byp_b;
		logic byp_a;
		logic enable;
		logic select;
	} gcm_ctrl_t;

	typedef enum {
		ST_RUN,
		ST_OLD,
		ST_NEW
	} gcm_state_t;

endpackage

`default_nettype wire

//--- hw/gcm_glitchless_clock_mux.sv
// Purpose: glitchless_clock_mux with enable, edge bypass, region
//          clock selection and io_clock_buffer pass-through
// Assumes: clock_in_a/b and the global clock bus toggle far slower than
//          clock, so each is sampled through two flip-flops
// Notes:   the handover edge is the one that reaches the init level
// Function
// - stopped old clock blocks an edge switch
// - bypass drops glitch protection, no edge wait
// - both bypasses switch at once
// - wait old falling edge, then new one
// - enable low parks output after falling edge
// - eight region clocks from any global clock
// - io buffer passes its clock straight through
// - init level sets reset and handover level
// - new clock within three slower-clock cycles
`default_nettype none

module gcm_glitchless_clock_mux
	import gcm_pkg::*;
#(
	parameter logic INIT_OUT    = 1'b0,
	parameter logic BOOT_PICK_A = 1'b0,
	parameter logic BOOT_PICK_B = 1'b0,
	parameter int   NUM_GLOBAL  = 32
)
(
	// system
	input  wire logic                  clock,
	input  wire logic                  rst_b,
	// apb slave
	input  wire logic [ADDR_W-1:0]     paddr,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [31:0]           pwdata,
	output var  logic [31:0]           prdata,
	output      logic                  pready,
	output      logic                  pslverr,
	// muxed clocks
	input  wire logic                  clock_in_a,
	input  wire logic                  clock_in_b,
	output var  logic                  mux_clk_out,
	// region clock selection
	input  wire logic [NUM_GLOBAL-1:0] gclk_bus,
	output var  logic [REGION_CLKS-1:0] region_clk,
	// io clock buffer
	input  wire logic                  io_clk_in,
	output      logic                  io_clk_out
);

	// elaboration checks refuse settings the logic cannot serve
	if (BOOT_PICK_A && BOOT_PICK_B)
	begin : g_bad_pick
		$error("both boot picks set");
	end
	if (NUM_GLOBAL < 2 || NUM_GLOBAL > (1 << SEL_W))
	begin : g_bad_width
		$error("NUM_GLOBAL out of range");
	end

	gcm_ctrl_t          ctrl;
	gcm_state_t         st;
	gcm_state_t         next_st;
	logic               cur;
	logic               next_cur;
	logic               gate;
	logic               next_gate;
	logic               next_out;
	logic [1:0]         clk_meta;
	logic [1:0]         clk_sync;
	logic [1:0]         clk_prev;
	logic [NUM_GLOBAL-1:0] g_meta;
	logic [NUM_GLOBAL-1:0] g_sync;
	logic [SEL_W-1:0]   region_sel [REGION_CLKS];
	logic [63:0]        map_word;
	logic [STAT_W-1:0]  status;

	// bus decode
	wire acc      = psel & penable;
	wire wr       = acc & pwrite;
	wire hit_ctrl = (paddr == ADDR_CTRL);
	wire hit_stat = (paddr == ADDR_STAT);
	wire hit_lo   = (paddr == ADDR_MAP_LO);
	wire hit_hi   = (paddr == ADDR_MAP_HI);
	wire mapped   = hit_ctrl | hit_stat | hit_lo | hit_hi;
	wire [31:0] rd_data =
		hit_ctrl ? {28'h0000000, ctrl} :
		hit_stat ? {28'h0000000, status} :
		hit_lo   ? map_word[31:0] :
		hit_hi   ? map_word[63:32] : 32'h00000000;

	// zero-wait slave; read data is captured in the setup cycle
	assign pready  = 1'b1;
	assign pslverr = acc & ~mapped;

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			prdata <= 32'h00000000;
		else if (psel && !penable)
			prdata <= rd_data;
	end

	// control register; a write steers the mux on the next edge
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			ctrl <= '{byp_b: CTRL_BYP_RST, byp_a: CTRL_BYP_RST,
			          enable: CTRL_EN_RST, select: BOOT_PICK_B};
		else if (wr && hit_ctrl)
			ctrl <= gcm_ctrl_t'(pwdata[3:0]);
	end

	// two-flop synchronisers; only the second stage is read
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			clk_meta <= {INIT_OUT, INIT_OUT};
			clk_sync <= {INIT_OUT, INIT_OUT};
			clk_prev <= {INIT_OUT, INIT_OUT};
			g_meta   <= '0;
			g_sync   <= '0;
		end
		else
		begin
			clk_meta <= {clock_in_b, clock_in_a};
			clk_sync <= clk_meta;
			clk_prev <= clk_sync;
			g_meta   <= gclk_bus;
			g_sync   <= g_meta;
		end
	end

	// per-source view: old is the running source, new the other one
	wire old_byp  = cur ? ctrl.byp_b : ctrl.byp_a;
	wire new_byp  = cur ? ctrl.byp_a : ctrl.byp_b;
	wire old_lvl  = clk_sync[cur];
	wire want_new = (ctrl.select != cur);
	// handover edge: the sampled clock reaches the init level
	wire old_hand = (clk_prev[cur] != INIT_OUT) &&
	                (clk_sync[cur] == INIT_OUT);
	wire new_hand = (clk_prev[~cur] != INIT_OUT) &&
	                (clk_sync[~cur] == INIT_OUT);
	wire old_done = old_byp | old_hand;
	wire new_done = new_byp | new_hand;

	// switch sequencer; a dead old clock never yields old_hand
	always_comb
	begin
		next_st  = st;
		next_cur = cur;
		case (st)
			ST_RUN:
			begin
				if (want_new && old_done && new_byp)
					next_cur = ~cur;
				else if (want_new && old_done)
					next_st = ST_NEW;
				else if (want_new)
					next_st = ST_OLD;
			end
			ST_OLD:
			begin
				if (!want_new)
					next_st = ST_RUN;
				else if (old_done && new_byp)
				begin
					next_cur = ~cur;
					next_st  = ST_RUN;
				end
				else if (old_done)
					next_st = ST_NEW;
			end
			ST_NEW:
			begin
				// completes even if select went back; run then returns
				if (new_done)
				begin
					next_cur = ~cur;
					next_st  = ST_RUN;
				end
			end
			default:
				next_st = ST_RUN;
		endcase
	end

	// enable takes effect at a handover edge of the source, or at once while that source is bypassed
	assign next_gate = (ctrl.enable != gate && old_done) ?
	                   ctrl.enable : gate;

	// output follows the source while running or waiting on the old edge, and gated on
	assign next_out = ((st == ST_RUN || st == ST_OLD) && gate) ?
	                  old_lvl : INIT_OUT;

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st          <= ST_RUN;
			cur         <= BOOT_PICK_B;
			gate        <= CTRL_EN_RST;
			mux_clk_out <= INIT_OUT;
		end
		else
		begin
			st          <= next_st;
			cur         <= next_cur;
			gate        <= next_gate;
			mux_clk_out <= next_out;
		end
	end

	assign status[STAT_SRC]  = cur;
	assign status[STAT_GATE] = gate;
	assign status[STAT_PEND] = (st != ST_RUN); // stuck here shows a dead clock
	assign status[STAT_OUT]  = mux_clk_out;

	// region map fields, one byte each, low bits hold the choice
	genvar gi;
	generate
		for (gi = 0; gi < REGION_CLKS; gi++)
		begin : g_region
			localparam int WB = (gi % FIELDS_WORD) * FIELD_W;
			wire hit = (gi < FIELDS_WORD) ? hit_lo : hit_hi;
			wire in_range = (int'(region_sel[gi]) < NUM_GLOBAL);
			assign map_word[gi*FIELD_W +: FIELD_W] =
				{{(FIELD_W-SEL_W){1'b0}}, region_sel[gi]};
			always_ff @(posedge clock or negedge rst_b)
			begin
				if (!rst_b)
				begin
					region_sel[gi] <= SEL_W'(gi);
					region_clk[gi] <= 1'b0;
				end
				else
				begin
					if (wr && hit)
						region_sel[gi] <= pwdata[WB +: SEL_W];
					region_clk[gi] <= in_range &&
					                  g_sync[region_sel[gi]];
				end
			end
		end
	endgenerate

	// io clock buffer: a plain wire, no enable and no divide
	assign io_clk_out = io_clk_in;

	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	sequence s_req_edge;
		st == ST_RUN && want_new && !old_done;
	endsequence

	sequence s_old_fall;
		st == ST_OLD && want_new && old_hand && !new_byp;
	endsequence

	byp_switch_a: assert property (st == ST_RUN && want_new && old_byp &&
		new_byp |=> cur != $past(cur) && st == ST_RUN)
		else $error("bypass switch was not immediate");

	old_wait_a: assert property (s_req_edge |=> st == ST_OLD &&
		cur == $past(cur))
		else $error("edge switch did not wait for old clock");

	old_keep_a: assert property (st == ST_OLD && !old_done |=>
		cur == $past(cur))
		else $error("source changed without old edge");

	new_park_a: assert property (s_old_fall ##1 st == ST_NEW |=>
		mux_clk_out == INIT_OUT)
		else $error("output not parked between clocks");

	byp_pass_a: assert property (st == ST_OLD && old_byp && want_new
		|=> st != ST_OLD)
		else $error("bypass still waited on an edge");

	gate_off_a: assert property (!ctrl.enable && gate && old_done
		|=> !gate ##1 mux_clk_out == INIT_OUT)
		else $error("enable low did not park output");

	gate_hold_a: assert property (!gate && !ctrl.enable |=>
		!gate && mux_clk_out == INIT_OUT)
		else $error("output left park while enable low");

	// a source phase lasts at least three samples, so must every pulse
	no_short_a: assert property (!ctrl.byp_a && !ctrl.byp_b &&
		$changed(mux_clk_out) |-> $past(mux_clk_out, 2) ==
		$past(mux_clk_out) && $past(mux_clk_out, 3) ==
		$past(mux_clk_out))
		else $error("output pulse shorter than a source phase");

	io_pass_a: assert property (io_clk_out == io_clk_in)
		else $error("io buffer output differs from input");

	region_sel_a: assert property (region_clk[0] ==
		$past(g_sync[region_sel[0]]))
		else $error("region clock not from chosen global");

endmodule

`default_nettype wire

//--- tb/gcm_clk_src.sv
// Purpose: test clock source for one input of the clock mux
// Assumes: half period well above the system clock period
// Notes:   holds its last level while run is low, like a dead source
`default_nettype none

module gcm_clk_src
#(
	parameter int HALF_NS = 200
)
(
	// control
	input  wire logic run,
	// clock out
	output var  logic clk
);
	timeunit 1ns;
	timeprecision 1ns;

	initial clk = 1'b0;

	// a stopped source never gives the mux its handover edge
	always #(HALF_NS) if (run) clk = ~clk;
endmodule

`default_nettype wire

//--- tb/glitch_free_clock_mux_tb.sv
// Purpose: self-checking bench for the glitch-free clock mux
// Assumes: source a period 8 system clocks, source b period 12
// Notes:   output rate is judged by counting rising edges
`default_nettype none

module glitch_free_clock_mux_tb;
	import gcm_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clock, rst_b, psel, penable, pwrite, er;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, seed, gbus, map;
	logic        pready, pslverr, run_a, run_b, clk_a, clk_b, mux_out;
	logic [7:0]  region_clk;
	logic        io_in, io_out;
	int          n_errors, total_checks, sel_q[$];

	// boot picks both left clear: at most one may ever be set
	gcm_glitchless_clock_mux #(.BOOT_PICK_A(1'b0), .BOOT_PICK_B(1'b0))
		uut (.clock(clock), .rst_b(rst_b),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .clock_in_a(clk_a), .clock_in_b(clk_b),
		.mux_clk_out(mux_out), .gclk_bus(gbus), .region_clk(region_clk),
		.io_clk_in(io_in), .io_clk_out(io_out));
	gcm_clk_src #(.HALF_NS(200)) src_a (.run(run_a), .clk(clk_a));
	gcm_clk_src #(.HALF_NS(300)) src_b (.run(run_b), .clk(clk_b));

	// 50 ns system clock
	always #25 clock = ~clock;

	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask

	// setup, then access held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int i;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		for (i = 0; i < 16; i++)
		begin
			@(posedge clock);
			if (pready === 1'b1)
				break;
		end
		if (i == 16)
		begin
			chk("pready", 1, 0);
			test_done();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// poll the current source bit under a bounded count of reads
	task automatic wsrc(input logic v, input int lim);
		int i;
		for (i = 0; i < lim; i++)
		begin
			apb(0, ADDR_STAT, 0, rd, er);
			if (rd[STAT_SRC] === v)
				break;
		end
		chk("source", v, rd[STAT_SRC]);
		if (i == lim)
			test_done();
	endtask

	// rising edges of the output over a window, within one edge;
	// a parked output must show none at all
	task automatic cnt(input int cyc, input int exp);
		int n;
		logic p;
		n = 0;
		p = mux_out;
		repeat (cyc)
		begin
			@(posedge clock);
			if (mux_out === 1'b1 && p === 1'b0)
				n++;
			p = mux_out;
		end
		total_checks++;
		if (n < exp - 1 || n > exp + 1 || (exp == 0 && n != 0))
		begin
			n_errors++;
			$display("[ERR] edges exp %0d got %0d", exp, n);
		end
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		clock = 0; rst_b = 0; psel = 0; penable = 0; pwrite = 0;
		paddr = 0; pwdata = 0; run_a = 1; run_b = 1; gbus = 0;
		io_in = 0; seed = 32'hc530dde9;
		repeat (5) @(posedge clock);
		chk("init", 0, mux_out);
		rst_b <= 1'b1;
		apb(0, ADDR_CTRL, 0, rd, er);
		chk("ctrl", 32'h2, rd);
		apb(0, 8'h10, 0, rd, er);
		chk("slverr", 1, er);
		cnt(96, 12);
		// edge handover to b, bounded by three slow cycles
		apb(1, ADDR_CTRL, 32'h3, rd, er);
		wsrc(1, 12);
		cnt(96, 8);
		// dead old source blocks the switch until bypassed
		run_b <= 1'b0;
		apb(1, ADDR_CTRL, 32'h2, rd, er);
		repeat (60) @(posedge clock);
		apb(0, ADDR_STAT, 0, rd, er);
		chk("pending", 32'h5, rd & 32'h5);
		apb(1, ADDR_CTRL, 32'ha, rd, er);
		wsrc(0, 4);
		// both bypasses: switch to the dead source at once
		apb(1, ADDR_CTRL, 32'hf, rd, er);
		apb(0, ADDR_STAT, 0, rd, er);
		chk("at once", 1, rd[STAT_SRC]);
		// user logic stops the clock by enable and keeps select
		run_b <= 1'b1;
		apb(1, ADDR_CTRL, 32'h1, rd, er);
		repeat (40) @(posedge clock);
		cnt(96, 0);
		chk("parked", 0, mux_out);
		apb(0, ADDR_STAT, 0, rd, er);
		chk("stat off", 32'h1, rd);
		// enable back on: b passes again after its next fall
		apb(1, ADDR_CTRL, 32'h3, rd, er);
		repeat (20) @(posedge clock);
		cnt(96, 8);
		// mid-run reset returns control and source to boot values
		rst_b <= 1'b0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		apb(0, ADDR_CTRL, 0, rd, er);
		chk("ctrl rst", 32'h2, rd);
		apb(0, ADDR_STAT, 0, rd, er);
		chk("stat rst", 32'h2, rd & 32'h7);
		// only the new source bypassed: one old fall is enough
		apb(1, ADDR_CTRL, 32'hb, rd, er);
		wsrc(1, 4);
		// region clocks from random global indices
		repeat (4)
		begin
			seed = xs(seed);
			map = seed & 32'h1f1f1f1f;
			apb(1, ADDR_MAP_LO, seed, rd, er);
			apb(0, ADDR_MAP_LO, 0, rd, er);
			chk("map lo", map, rd);
			for (int i = 0; i < 4; i++)
				sel_q.push_back(int'(map[8*i +: 5]));
			seed = xs(seed);
			map = seed & 32'h1f1f1f1f;
			apb(1, ADDR_MAP_HI, seed, rd, er);
			apb(0, ADDR_MAP_HI, 0, rd, er);
			chk("map hi", map, rd);
			for (int i = 0; i < 4; i++)
				sel_q.push_back(int'(map[8*i +: 5]));
			seed = xs(seed);
			gbus <= seed;
			io_in <= seed[7];
			repeat (6) @(posedge clock);
			for (int i = 0; i < 8; i++)
				chk("region", gbus[sel_q.pop_front()], region_clk[i]);
			chk("io", io_in, io_out);
		end
		test_done();
	end
endmodule

`default_nettype wire
